/* hdl/xbi_bus.sv */
// Purpose: Asynchronous external bus unit with arbitration and interrupts
// Assumes: Pin inputs synchronous to clock_in; core issues one request
// Notes:   low_power_in freezes all state; clock may be stopped
`timescale 1ns/1ps
module xbi_bus
    import xbi_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire logic              low_power_in,
    input  wire logic              width8_in,
    input  wire logic              halt_n_in,
    input  wire logic              req_in,
    input  wire logic              req_iack_in,
    input  wire logic              req_rnw_in,
    input  wire logic              req_word_in,
    input  wire logic [ADDR_W-1:0] req_addr_in,
    input  wire logic [DATA_W-1:0] req_wdata_in,
    input  wire logic [2:0]        req_fc_in,
    input  wire logic [2:0]        irq_mask_in,
    input  wire logic [DATA_W-1:0] data_lines_in,
    input  wire logic              transfer_acknowledge_n_in,
    input  wire logic              bus_error_input_n_in,
    input  wire logic              auto_vector_request_n_in,
    input  wire logic              bus_request_n_in,
    input  wire logic [2:0]        priority_level_n_in,
    output wire logic [ADDR_W-1:0] address_lines_out,
    output wire logic              address_oe_n_out,
    output wire logic [DATA_W-1:0] data_lines_out,
    output wire logic              data_oe_n_out,
    output wire logic              address_valid_strobe_n_out,
    output wire logic              upper_byte_strobe_n_out,
    output wire logic              lower_byte_strobe_n_out,
    output wire logic              read_not_write_out,
    output wire logic              control_oe_n_out,
    output wire logic [2:0]        function_code_out,
    output wire logic              bus_grant_n_out,
    output wire logic              busy_out,
    output wire logic              done_out,
    output wire logic              bus_error_input_out,
    output wire logic [DATA_W-1:0] rdata_out,
    output wire logic [7:0]        vector_out,
    output wire logic              autovec_out,
    output wire logic              irq_pending_out,
    output wire logic [2:0]        irq_level_out,
    output wire logic              halted_out
);
    xbi_bus_s   q;
    xbi_bus_s   d;
    logic       ack;

    // ------------------------------------------------------------
    // Interrupt sampler
    // ------------------------------------------------------------
    xbi_irq u_irq (
        .clock_in            (clock_in),
        .rst_in              (rst_in),
        .freeze_in           (low_power_in),
        .priority_level_n_in (priority_level_n_in),
        .mask_in             (irq_mask_in),
        .level_out           (irq_level_out),
        .pending_out         (irq_pending_out)
    );

    // Any of the three cycle terminations
    assign ack = !transfer_acknowledge_n_in || !bus_error_input_n_in ||
                 (q.iack && !auto_vector_request_n_in);

    // ------------------------------------------------------------
    // Bus sequencer
    // ------------------------------------------------------------
    always_comb begin
        d      = q;
        if (!low_power_in) begin
            d.done = 1'b0;
            unique case (q.st)
                ST_IDLE: begin
                    if (!halt_n_in) begin
                        d.st     = ST_HALT;
                        d.halted = 1'b1;
                    end else if (!bus_request_n_in) begin
                        d.st   = ST_REL;
                        d.bg_n = 1'b0;
                        d.rel  = 1'b1;
                    end else if (req_in) begin
                        d.st   = ST_ADDR;
                        d.busy = 1'b1;
                        d.bus_error_input = 1'b0;
                        d.auto_vector_request = 1'b0;
                        d.w8   = width8_in;
                        d.iack = req_iack_in;
                        if (req_iack_in) begin
                            d.addr = {IACK_HIGH, irq_level_out,
                                      1'b1};
                            d.fc   = FC_IACK;
                            d.rnw  = 1'b1;
                            d.word = 1'b0;
                        end else begin
                            d.addr = req_word_in ?
                                     {req_addr_in[ADDR_W-1:1], 1'b0} :
                                     req_addr_in;
                            d.fc   = req_fc_in;
                            d.rnw  = req_rnw_in;
                            d.word = req_word_in;
                        end
                        d.part      = width8_in && req_word_in &&
                                      !req_iack_in;
                        d.wdata     = req_wdata_in;
                        // Byte writes copied to both lanes
                        d.dout      = (req_word_in && !width8_in) ?
                                      req_wdata_in :
                                      (req_word_in ?
                                       {8'h00, req_wdata_in[15:8]} :
                                       {2{req_wdata_in[7:0]}});
                        d.dout_oe_n = req_iack_in || req_rnw_in;
                    end
                end
                ST_HALT: begin
                    if (halt_n_in) begin
                        d.st     = ST_IDLE;
                        d.halted = 1'b0;
                    end
                end
                ST_ADDR: begin
                    // Address settled a cycle before the strobe
                    d.st   = ST_STRB;
                    d.as_n = 1'b0;
                    {d.uds_n, d.lds_n} =
                        lane_strobe_n(q.w8, q.word, q.addr[0]);
                end
                ST_STRB: begin
                    if (!bus_request_n_in)
                        d.bg_n = 1'b0;
                    if (ack) begin
                        d.st    = ST_TERM;
                        d.as_n  = 1'b1;
                        d.uds_n = 1'b1;
                        d.lds_n = 1'b1;
                        d.bus_error_input  = !bus_error_input_n_in;
                        if (q.iack) begin
                            d.auto_vector_request = !auto_vector_request_n_in;
                            d.vec  = d.auto_vector_request ?
                                     AUTOVEC_BASE + {5'h00, q.addr[3:1]} :
                                     data_lines_in[7:0];
                        end else if (q.w8) begin
                            if (q.part)
                                d.rdata[15:8] = data_lines_in[7:0];
                            else if (q.word)
                                d.rdata[7:0] = data_lines_in[7:0];
                            else
                                d.rdata = {8'h00, data_lines_in[7:0]};
                        end else if (q.word) begin
                            d.rdata = data_lines_in;
                        end else begin
                            d.rdata = {8'h00, q.addr[0] ?
                                       data_lines_in[7:0] :
                                       data_lines_in[15:8]};
                        end
                    end
                end
                ST_TERM: begin
                    if (q.part && !q.bus_error_input) begin
                        // Second byte of a word on the narrow bus
                        d.st     = ST_ADDR;
                        d.part   = 1'b0;
                        d.addr   = q.addr | {{(ADDR_W-1){1'b0}}, 1'b1};
                        d.dout   = {8'h00, q.wdata[7:0]};
                    end else begin
                        d.done      = 1'b1;
                        d.busy      = 1'b0;
                        d.dout_oe_n = 1'b1;
                        if (!q.bg_n) begin
                            d.st  = ST_REL;
                            d.rel = 1'b1;
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                end
                ST_REL: begin
                    if (bus_request_n_in) begin
                        d.st   = ST_IDLE;
                        d.bg_n = 1'b1;
                        d.rel  = 1'b0;
                    end
                end
                default: d = BUS_RESET;
            endcase
        end
    end

    // Static flops only, safe with a stopped clock
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in)
            q <= BUS_RESET;
        else
            q <= d;
    end

    // ------------------------------------------------------------
    // Outputs, all straight from state flops
    // ------------------------------------------------------------
    assign address_lines_out          = q.addr;
    assign address_oe_n_out           = q.rel;
    assign data_lines_out             = q.dout;
    assign data_oe_n_out              = q.dout_oe_n;
    assign address_valid_strobe_n_out = q.as_n;
    assign upper_byte_strobe_n_out    = q.uds_n;
    assign lower_byte_strobe_n_out    = q.lds_n;
    assign read_not_write_out         = q.rnw;
    assign control_oe_n_out           = q.rel;
    assign function_code_out          = q.fc;
    assign bus_grant_n_out            = q.bg_n;
    assign busy_out                   = q.busy;
    assign done_out                   = q.done;
    assign bus_error_input_out                   = q.bus_error_input;
    assign rdata_out                  = q.rdata;
    assign vector_out                 = q.vec;
    assign autovec_out                = q.auto_vector_request;
    assign halted_out                 = q.halted;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_acked;
        q.st == ST_STRB && ack && !low_power_in;
    endsequence
    sequence s_closed;
        q.as_n && q.uds_n && q.lds_n && q.st == ST_TERM;
    endsequence

    a_iack_address: assert property (!q.as_n && q.iack |->
        q.addr[23:4] == IACK_HIGH && q.addr[0] && q.fc == FC_IACK)
        else $error("Acknowledge address pattern wrong");
    a_strobe_valid: assert property (!q.as_n |->
        !q.rel && $past(q.st) == ST_ADDR || $past(!q.as_n))
        else $error("Strobe low without address phase");
    a_rnw_stable: assert property (!q.as_n && $past(!q.as_n) |->
        $stable(q.rnw) && $stable(q.addr))
        else $error("Direction or address moved in strobe");
    a_narrow_lane: assert property (!q.as_n && q.w8 |->
        q.uds_n && !q.lds_n)
        else $error("Narrow mode used upper lane");
    a_ack_close: assert property (s_acked |=> s_closed)
        else $error("Strobes not negated after acknowledge");
    a_wait_hold: assert property (q.st == ST_STRB && !ack |=>
        !q.as_n)
        else $error("Cycle ended without acknowledge");
    a_grant_req: assert property (q.st == ST_IDLE && halt_n_in &&
        !bus_request_n_in && !low_power_in |=> !q.bg_n && q.rel)
        else $error("Bus request not granted");
    a_nmi_pending: assert property (irq_level_out == LEVEL_NMI |->
        irq_pending_out)
        else $error("Level 7 was masked");
    a_autovec_vec: assert property (s_acked and q.iack &&
        !auto_vector_request_n_in |=>
        q.vec == AUTOVEC_BASE + {5'h00, q.addr[3:1]})
        else $error("Autovector not taken from level");
    a_freeze_hold: assert property (low_power_in |=> $stable(q))
        else $error("State changed in low power");
    a_fc_valid: assert property (!q.as_n |-> $stable(q.fc))
        else $error("Function code changed under strobe");
    a_bus_error_input_flag: assert property (s_acked and
        !bus_error_input_n_in |=> q.bus_error_input ##1 q.done && q.bus_error_input)
        else $error("Bus error not reported");

endmodule : xbi_bus

/* shared/xbi_pkg.sv */
// Purpose: Constants, types and helpers of the processor bus interface
// Assumes: One 20 MHz clock, active-low bus pins, static width select
// Notes:   Contract list below; each line states one rule of the interface
//
// Contract
// - The 24-bit address is driven for every cycle, acknowledge included.
// - Acknowledge cycles put the level on lines 3..1, all others high.
// - The width-select input fixes 8- or 16-bit transfers.
// - The address strobe is low only while the address is valid.
// - read_not_write marks each cycle as a read or a write.
// - Upper and lower byte strobes select the active byte lanes.
// - Bus grant tells masters the bus is freed when the cycle ends; on a narrow word it is freed after the second byte cycle.
// - Three encoded priority inputs give seven interrupt levels.
// - Level 7 is highest and cannot be masked.
// - Auto vector request makes the vector come from the level.
// - Reset and halt act on the device; bus error fails the cycle.
// - Low-power mode keeps every bit of state unchanged.
// - All logic is static, so the clock may stop indefinitely.
// - Function code outputs are valid whenever the strobe is low.
package xbi_pkg;

    // ------------------------------------------------------------
    // Widths and fixed codes
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 24;
    localparam int          DATA_W       = 16;
    localparam logic [19:0] IACK_HIGH    = 20'hfffff;
    localparam logic [2:0]  FC_IACK      = 3'h7;
    localparam logic [7:0]  AUTOVEC_BASE = 8'h18;
    localparam logic [2:0]  LEVEL_NMI    = 3'h7;

    // Gray codes along idle, address, strobe, terminate
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_STRB = 3'h3,
        ST_TERM = 3'h2,
        ST_REL  = 3'h6,
        ST_HALT = 3'h4
    } xbi_state_e;

    // Whole state of the bus sequencer; the interrupt sampler keeps its own
    typedef struct packed {
        xbi_state_e         st;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
        logic [DATA_W-1:0]  dout;
        logic [DATA_W-1:0]  rdata;
        logic [7:0]         vec;
        logic [2:0]         fc;
        logic               rnw;
        logic               as_n;
        logic               uds_n;
        logic               lds_n;
        logic               bg_n;
        logic               rel;
        logic               dout_oe_n;
        logic               w8;
        logic               word;
        logic               part;
        logic               iack;
        logic               auto_vector_request;
        logic               busy;
        logic               done;
        logic               bus_error_input;
        logic               halted;
    } xbi_bus_s;

    localparam xbi_bus_s BUS_RESET = '{
        st: ST_IDLE, addr: '0, wdata: '0, dout: '0, rdata: '0, vec: '0,
        fc: '0, rnw: 1'b1, as_n: 1'b1, uds_n: 1'b1, lds_n: 1'b1,
        bg_n: 1'b1, rel: 1'b0, dout_oe_n: 1'b1, w8: 1'b0, word: 1'b0,
        part: 1'b0, iack: 1'b0, auto_vector_request: 1'b0, busy: 1'b0, done: 1'b0,
        bus_error_input: 1'b0, halted: 1'b0};

    // Interrupt sampler state
    typedef struct packed {
        logic [2:0] level;
        logic       pending;
    } xbi_irq_s;

    // Active-low encoded priority pins to a level, 0 meaning none
    function automatic logic [2:0] ipl_decode(input logic [2:0] pins_n);
        return ~pins_n;
    endfunction : ipl_decode

    // Active-low {upper, lower} strobes for width, size and A0
    function automatic logic [1:0] lane_strobe_n(input logic w8,
                                                 input logic word,
                                                 input logic a0);
        if (w8)
            return 2'h2;
        else if (word)
            return 2'h0;
        else
            return a0 ? 2'h2 : 2'h1;
    endfunction : lane_strobe_n

endpackage : xbi_pkg

/* hdl/xbi_irq.sv */
// Purpose: Samples the encoded interrupt priority pins
// Assumes: Pins synchronous to clock_in, active low
// Notes:   Level 7 ignores the mask
`timescale 1ns/1ps
module xbi_irq
    import xbi_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       freeze_in,
    input  wire logic [2:0] priority_level_n_in,
    input  wire logic [2:0] mask_in,
    output wire logic [2:0] level_out,
    output wire logic       pending_out
);
    xbi_irq_s s_q;
    xbi_irq_s s_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (!freeze_in) begin
            s_d.level   = ipl_decode(priority_level_n_in);
            s_d.pending = (s_d.level == LEVEL_NMI) ||
                          (s_d.level > mask_in);
        end
    end

    // Plain flops, no clock-dependent storage
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign level_out   = s_q.level;
    assign pending_out = s_q.pending;

endmodule : xbi_irq

/* test/xbi_responder.sv */
// Purpose: Behavioural memory or peripheral on the far side of the bus
// Assumes: Pins change just after the rising clock edge
// Notes:   Released data lines toggle every cycle, never hold stale data
`timescale 1ns/1ps
module xbi_responder (
    input  wire logic        clock_in,
    input  wire logic        address_valid_strobe_n_in,
    input  wire logic        upper_byte_strobe_n_in,
    input  wire logic        lower_byte_strobe_n_in,
    input  wire logic        read_not_write_in,
    input  wire logic [23:0] address_lines_in,
    input  wire logic [3:0]  wait_in,
    input  wire logic [1:0]  mode_in,
    output logic             transfer_acknowledge_n_out,
    output logic             bus_error_input_n_out,
    output logic             auto_vector_request_n_out,
    output logic [15:0]      data_lines_out
);
    logic [3:0] count_q;
    logic       sel;
    logic       due;

    // Selected while the address strobe and one lane strobe are low
    assign sel = !address_valid_strobe_n_in &&
                 !(upper_byte_strobe_n_in && lower_byte_strobe_n_in);
    assign due = sel && count_q >= wait_in;

    // Idle levels before the first strobe
    initial begin
        count_q = 4'h0;
        transfer_acknowledge_n_out = 1'b1;
        bus_error_input_n_out = 1'b1;
        auto_vector_request_n_out = 1'b1;
        data_lines_out = 16'h0000;
    end

    // Answer after the chosen wait; mode picks ack, error or autovector
    always @(posedge clock_in) begin
        count_q <= sel ? count_q + 4'h1 : 4'h0;
        transfer_acknowledge_n_out <= !(due && mode_in == 2'h0);
        bus_error_input_n_out <= !(due && mode_in == 2'h1);
        auto_vector_request_n_out <= !(due && mode_in == 2'h2);
        if (sel && read_not_write_in)
            data_lines_out <= address_lines_in[15:0] ^ 16'h5a3c;
        else
            data_lines_out <= ~data_lines_out;
    end
endmodule : xbi_responder

/* test/testbench.sv */
// Purpose: Self-checking bench of the external bus unit
// Assumes: Far side modelled by xbi_responder, read data = addr ^ 5a3c
// Notes:   Inputs change on the rising edge, outputs read on falling
`timescale 1ns/1ps
module testbench
    import xbi_pkg::*;
;
    logic              clock_in = 1'b0, rst_in = 1'b1, low_power_in = 1'b0;
    logic              width8_in = 1'b0, halt_n_in = 1'b1, req_in = 1'b0;
    logic              req_iack_in = 1'b0, req_rnw_in = 1'b1;
    logic              req_word_in = 1'b1, bus_request_n_in = 1'b1;
    logic [ADDR_W-1:0] req_addr_in = '0, address_lines_out, m_addr;
    logic [DATA_W-1:0] req_wdata_in = '0, data_lines_in, resp_data;
    logic [DATA_W-1:0] data_lines_out, rdata_out, m_data;
    logic [2:0]        req_fc_in = 3'h5, irq_mask_in = 3'h0, m_fc;
    logic [2:0]        priority_level_n_in = 3'h7, function_code_out;
    logic [2:0]        irq_level_out;
    logic [3:0]        wait_cyc = 4'h0;
    logic [1:0]        mode = 2'h0;
    logic              transfer_acknowledge_n_in, bus_error_input_n_in;
    logic              auto_vector_request_n_in, address_oe_n_out;
    logic              data_oe_n_out, address_valid_strobe_n_out;
    logic              upper_byte_strobe_n_out, lower_byte_strobe_n_out;
    logic              read_not_write_out, control_oe_n_out, bus_grant_n_out;
    logic              busy_out, done_out, bus_error_input_out, autovec_out;
    logic              irq_pending_out, halted_out, m_uds, m_lds, as_prev;
    logic [7:0]        vector_out;
    logic [25:0]       snap;
    int                err_total = 0, samples_checked = 0, as_cnt = 0, c0;

    always #25 clock_in = ~clock_in;
    // Wire level of the data pins from the DUT's output enable alone
    assign data_lines_in = data_oe_n_out ? resp_data : data_lines_out;

    xbi_bus DUT (.clock_in, .rst_in, .low_power_in, .width8_in, .halt_n_in,
        .req_in, .req_iack_in, .req_rnw_in, .req_word_in, .req_addr_in,
        .req_wdata_in, .req_fc_in, .irq_mask_in, .data_lines_in,
        .transfer_acknowledge_n_in, .bus_error_input_n_in,
        .auto_vector_request_n_in, .bus_request_n_in, .priority_level_n_in,
        .address_lines_out, .address_oe_n_out, .data_lines_out,
        .data_oe_n_out, .address_valid_strobe_n_out,
        .upper_byte_strobe_n_out, .lower_byte_strobe_n_out,
        .read_not_write_out, .control_oe_n_out, .function_code_out,
        .bus_grant_n_out, .busy_out, .done_out, .bus_error_input_out, .rdata_out,
        .vector_out, .autovec_out, .irq_pending_out, .irq_level_out,
        .halted_out);

    xbi_responder far_end (.clock_in,
        .address_valid_strobe_n_in(address_valid_strobe_n_out),
        .upper_byte_strobe_n_in(upper_byte_strobe_n_out),
        .lower_byte_strobe_n_in(lower_byte_strobe_n_out),
        .read_not_write_in(read_not_write_out),
        .address_lines_in(address_lines_out), .wait_in(wait_cyc),
        .mode_in(mode), .transfer_acknowledge_n_out(transfer_acknowledge_n_in),
        .bus_error_input_n_out(bus_error_input_n_in),
        .auto_vector_request_n_out(auto_vector_request_n_in),
        .data_lines_out(resp_data));

    // -------------------------------------------------------------
    // Checking helpers
    // -------------------------------------------------------------
    task automatic chk(input logic [31:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
        end
    endtask : chk

    // Snapshot pins under the strobe; the address must not move there
    always @(posedge clock_in) begin
        if (address_valid_strobe_n_out === 1'b0) begin
            if (as_prev === 1'b0)
                chk(address_lines_out, m_addr, "address moved");
            else
                as_cnt++;
            m_addr = address_lines_out;
            m_fc = function_code_out;
            m_data = data_lines_in;
            {m_uds, m_lds} = {upper_byte_strobe_n_out, lower_byte_strobe_n_out};
        end
        as_prev = address_valid_strobe_n_out;
    end

    // Request pulse from the core side, taken in idle
    task automatic start(input logic iack, rnw, word,
                         input logic [23:0] a, input logic [15:0] wd);
        @(posedge clock_in);
        req_in <= 1'b1;
        req_iack_in <= iack;
        req_rnw_in <= rnw;
        req_word_in <= word;
        req_addr_in <= a;
        req_wdata_in <= wd;
        @(posedge clock_in);
        req_in <= 1'b0;
        c0 = as_cnt;
    endtask : start

    // Bounded wait; a missing done ends the run
    task automatic wait_done();
        for (int n = 0; n < 40 && done_out !== 1'b1; n++)
            @(negedge clock_in);
        if (done_out !== 1'b1) begin
            chk(0, 1, "no done");
            test_done();
        end
    endtask : wait_done

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_word_byte();
        wait_cyc <= 4'h3;
        start(1'b0, 1'b1, 1'b1, 24'h812344, 16'h0);
        wait_done();
        chk(rdata_out, 16'h2344 ^ 16'h5a3c, "word read");
        chk(m_addr, 24'h812344, "address");
        chk(m_fc, 3'h5, "function code");
        chk({m_uds, m_lds}, 2'b00, "word lanes");
        chk(address_valid_strobe_n_out, 1'b1, "strobe released");
        for (int i = 0; i < 2; i++) begin
            start(1'b0, 1'b0, 1'b0, {23'h000080, i[0]}, 16'h00a5);
            wait_done();
            chk({m_uds, m_lds}, i ? 2'b10 : 2'b01, "byte lane");
            chk(m_data, 16'ha5a5, "byte data");
            chk(read_not_write_out, 1'b0, "write");
        end
        wait_cyc <= 4'h0;
    endtask : t_word_byte

    task automatic t_narrow();
        @(posedge clock_in);
        width8_in <= 1'b1;
        start(1'b0, 1'b1, 1'b1, 24'h000200, 16'h0);
        wait_done();
        chk(as_cnt - c0, 2, "two byte cycles");
        chk({m_uds, m_lds}, 2'b10, "lower lane only");
        chk(rdata_out, 16'h3c3d, "narrow read");
        mode <= 2'h1;
        start(1'b0, 1'b1, 1'b1, 24'h000300, 16'h0);
        wait_done();
        chk(as_cnt - c0, 1, "second cycle aborted");
        chk(bus_error_input_out, 1'b1, "bus error");
        @(posedge clock_in);
        mode <= 2'h0;
        width8_in <= 1'b0;
    endtask : t_narrow

    task automatic t_irq();
        for (int l = 1; l < 8; l++)
            for (int m = l - 1; m <= l; m++) begin
                @(posedge clock_in);
                priority_level_n_in <= ~l[2:0];
                irq_mask_in <= m[2:0];
                repeat (3) @(negedge clock_in);
                chk(irq_pending_out, l == 7 || l > m, "pending");
                chk(irq_level_out, l, "level");
            end
        mode <= 2'h2;
        start(1'b1, 1'b1, 1'b0, 24'h0, 16'h0);
        wait_done();
        chk(m_addr, {IACK_HIGH, 3'h7, 1'b1}, "ack address");
        chk(m_fc, FC_IACK, "ack function code");
        chk(vector_out, AUTOVEC_BASE + 8'h07, "vector");
        chk(autovec_out, 1'b1, "autovector");
        mode <= 2'h0;
    endtask : t_irq

    // Grant comes at once, bus is kept until the cycle ends
    task automatic t_arb();
        wait_cyc <= 4'h4;
        @(posedge clock_in);
        bus_request_n_in <= 1'b0;
        priority_level_n_in <= 3'h7;
        repeat (2) @(negedge clock_in);
        chk({bus_grant_n_out, address_oe_n_out}, 2'b01, "idle grant");
        @(posedge clock_in);
        bus_request_n_in <= 1'b1;
        start(1'b0, 1'b1, 1'b1, 24'h000010, 16'h0);
        repeat (2) @(posedge clock_in);
        bus_request_n_in <= 1'b0;
        repeat (2) @(negedge clock_in);
        chk(bus_grant_n_out, 1'b0, "grant");
        chk(address_oe_n_out, 1'b0, "still owner");
        wait_done();
        repeat (2) @(negedge clock_in);
        chk({address_oe_n_out, control_oe_n_out}, 2'b11, "released");
        start(1'b0, 1'b1, 1'b1, 24'h000010, 16'h0);
        @(negedge clock_in);
        chk(busy_out, 1'b0, "refused while granted");
        @(posedge clock_in);
        bus_request_n_in <= 1'b1;
        repeat (2) @(negedge clock_in);
        chk({bus_grant_n_out, address_oe_n_out}, 2'b10, "regained");
        wait_cyc <= 4'h0;
    endtask : t_arb

    task automatic t_halt_power();
        @(posedge clock_in);
        halt_n_in <= 1'b0;
        start(1'b0, 1'b1, 1'b1, 24'h000020, 16'h0);
        repeat (2) @(negedge clock_in);
        chk({halted_out, busy_out}, 2'b10, "halted");
        @(posedge clock_in);
        halt_n_in <= 1'b1;
        wait_cyc <= 4'h6;
        start(1'b0, 1'b1, 1'b1, 24'h000040, 16'h0);
        repeat (2) @(posedge clock_in);
        low_power_in <= 1'b1;
        repeat (2) @(negedge clock_in);
        snap = {address_lines_out, address_valid_strobe_n_out, busy_out};
        repeat (12) @(negedge clock_in);
        chk({address_lines_out, address_valid_strobe_n_out, busy_out},
            snap, "frozen");
        @(posedge clock_in);
        low_power_in <= 1'b0;
        wait_done();
        chk(rdata_out, 16'h0040 ^ 16'h5a3c, "resumed read");
        wait_cyc <= 4'h0;
    endtask : t_halt_power

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        t_word_byte();
        t_narrow();
        t_irq();
        t_arb();
        t_halt_power();
        test_done();
    end
endmodule : testbench
